// >>> rtl/crc_engine_regs.svh
/*
 Constants of the configurable check-value engine: widths, depths and
 reset values. Assumes inclusion by bare name from the rtl/ directory.
*/
// Summary of operation
// RULE_01 - Length field sets accumulator width, up to 16
// RULE_02 - Top and bottom polynomial terms forced to one
// RULE_03 - Polynomial bit 0 reads zero, acts one
// RULE_04 - Written terms fill everything between end terms
// RULE_05 - Only word-length data bits are used
// RULE_06 - Words pass staging shifter into accumulator
// RULE_07 - Bit order select picks MSb or LSb first
// RULE_08 - Accumulator seed is writable before starting
// RULE_09 - Low byte write latches word, starts processing
// RULE_10 - Augment select appends polynomial-length zero bits
// RULE_11 - Without augment, stop after last data bit
// RULE_12 - LSb-first with augment gives reversed result
// RULE_13 - Busy falling edge sets completion flag
// RULE_14 - Completion flag cleared only by software
// RULE_15 - Software and scanner words share one shifter
// RULE_16 - Word length field holds length minus one
// RULE_17 - Go control enables the shifting process
// RULE_18 - Full shown while all input buffer entries are occupied; inputFull is registered and follows one cycle late
// RULE_19 - Busy while shifting; then accumulator valid
// RULE_20 - One bit per clock, conditional polynomial XOR
`ifndef CRC_ENGINE_REGS_SVH
`define CRC_ENGINE_REGS_SVH

`define CRC_ACC_W 16
`define CRC_LEN_W 4
`define CRC_CNT_W 5
`define CRC_FIFO_DEPTH 8
`define CRC_FIFO_PTR_W 3
`define CRC_ACC_RESET 16'h0000
`define CRC_POLY_RESET 16'h0000
`define CRC_BYTE_RESET 8'h00
`define CRC_ALL_ONES 16'hFFFF
`define CRC_TOP_LEN 4'hF

`endif

// >>> rtl/crc_engine_pkg.sv
/*
 Types shared by the check-value engine: configuration carrier, shifter
 states and the accumulator width mask. Assumes the constants header.
*/
`include "crc_engine_regs.svh"

package crc_engine_pkg;

	typedef struct packed {
		logic [`CRC_LEN_W-1:0] polyLength;
		logic [`CRC_LEN_W-1:0] wordLength;
		logic bitOrderSelect;
		logic zeroAugmentSelect;
	} crc_cfg_t;

	typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_AUG} shift_state_t;

	function automatic logic [`CRC_ACC_W-1:0] lenMask(
		input logic [`CRC_LEN_W-1:0] len);
		return `CRC_ALL_ONES >> (`CRC_TOP_LEN - len);
	endfunction

endpackage

// >>> rtl/crc_word_fifo.sv
/*
 Word FIFO in front of the staging shifter, valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
module crc_word_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8,
	parameter int PTR_W = 3
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady,
	output logic [PTR_W:0] level
);
	logic [W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_r;
	logic [PTR_W-1:0] rdPtr_r;
	logic [PTR_W:0] count_r;
	logic push;
	logic pop;

	assign inReady = (count_r != (PTR_W+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	assign level = count_r;
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end
endmodule // crc_word_fifo

// >>> rtl/crc_bit_step.sv
/*
 One division step of the XOR shift register: shifts one bit into the
 accumulator and folds in the polynomial when the top bit leaves.
*/
`include "crc_engine_regs.svh"

module crc_bit_step
	import crc_engine_pkg::*;
(
	input wire logic [`CRC_ACC_W-1:0] accIn,
	input wire logic dataBit,
	input wire logic [`CRC_ACC_W-1:0] polyEff,
	input wire logic [`CRC_LEN_W-1:0] polyLength,
	output logic [`CRC_ACC_W-1:0] accOut
);
	logic topBit;
	logic [`CRC_ACC_W-1:0] shifted;

	// The implicit top term is the bit that falls out of the accumulator
	assign topBit = accIn[polyLength]; // RULE_02
	assign shifted = {accIn[`CRC_ACC_W-2:0], dataBit};
	assign accOut = (shifted ^ (topBit ? polyEff : `CRC_ACC_RESET))
		& lenMask(polyLength); // RULE_01 RULE_20
endmodule // crc_bit_step

// >>> rtl/crc_engine.sv
/*
 Configurable check-value engine: polynomial and seed storage, input
 word assembly from software bytes or scanner words, a word FIFO, the
 staging shifter and the accumulator with completion flag. Assumes the
 control bits are held stable while busy and all inputs are synchronous.
*/
`include "crc_engine_regs.svh"

module crc_engine
	import crc_engine_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire crc_cfg_t crcCfg,
	input wire logic goCtrl,
	input wire logic polyWrEn,
	input wire logic [`CRC_ACC_W-1:0] polyWrData,
	input wire logic seedWrEn,
	input wire logic [`CRC_ACC_W-1:0] seedWrData,
	input wire logic wordHighWrEn,
	input wire logic wordLowWrEn,
	input wire logic [7:0] wordByte,
	input wire logic scanValid,
	input wire logic [`CRC_ACC_W-1:0] scanWord,
	input wire logic completionFlagClr,
	output logic [`CRC_ACC_W-1:0] checkAccumulator,
	output logic [`CRC_ACC_W-1:0] polynomialTerms,
	output logic inputFull,
	output logic busy,
	output logic completionFlag,
	output logic scanReady
);
	logic [`CRC_ACC_W-1:0] acc_r;
	logic [`CRC_ACC_W-1:0] polyTerms_r;
	logic [7:0] wordHigh_r;
	logic [`CRC_ACC_W-1:0] staging_r;
	logic [`CRC_CNT_W-1:0] bitCnt_r;
	shift_state_t state_r;
	shift_state_t stateNxt;
	logic busy_r;
	logic busyNxt;
	logic flag_r;
	logic full_r;
	logic scanReady_r;

	logic [`CRC_ACC_W-1:0] polyEff;
	logic [`CRC_ACC_W-1:0] accNext;
	logic [`CRC_ACC_W-1:0] pushWord;
	logic [`CRC_ACC_W-1:0] popWord;
	logic [`CRC_ACC_W-1:0] maskedWord;
	logic [`CRC_FIFO_PTR_W:0] fifoLevel;
	logic scanTake;
	logic fifoInValid;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	logic shiftBit;
	logic stepEn;
	logic lastBit;

	// Bit 0 is stored as zero but used as one
	assign polyEff = {polyTerms_r[`CRC_ACC_W-1:1], 1'b1}; // RULE_02 RULE_04

	// A low-byte write wins the FIFO port; the scanner retries next cycle
	assign scanTake = scanValid & scanReady_r & ~wordLowWrEn; // RULE_15
	assign pushWord = wordLowWrEn ? {wordHigh_r, wordByte} : scanWord; // RULE_09
	assign fifoInValid = wordLowWrEn | scanTake; // RULE_15

	assign fifoPop = (state_r == ST_IDLE) & goCtrl & fifoOutValid; // RULE_17
	assign maskedWord = popWord & lenMask(crcCfg.wordLength); // RULE_05

	assign shiftBit = (state_r == ST_DATA) &
		(crcCfg.bitOrderSelect ? staging_r[0]
			: staging_r[`CRC_ACC_W-1]); // RULE_07
	assign stepEn = goCtrl & (state_r != ST_IDLE);
	assign lastBit = (bitCnt_r == '0);

	crc_word_fifo #(
		.W(`CRC_ACC_W),
		.DEPTH(`CRC_FIFO_DEPTH),
		.PTR_W(`CRC_FIFO_PTR_W)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.inValid(fifoInValid),
		.inData(pushWord),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outData(popWord),
		.outReady(fifoPop),
		.level(fifoLevel)
	);

	crc_bit_step u_step (
		.accIn(acc_r),
		.dataBit(shiftBit),
		.polyEff(polyEff),
		.polyLength(crcCfg.polyLength),
		.accOut(accNext)
	);

	always_comb begin
		stateNxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (fifoPop) begin
					stateNxt = ST_DATA;
				end
			end
			ST_DATA: begin
				if (goCtrl && lastBit) begin
					// Zeros follow only once no further word is waiting
					if (fifoOutValid) begin
						stateNxt = ST_IDLE;
					end else if (crcCfg.zeroAugmentSelect) begin
						stateNxt = ST_AUG; // RULE_10
					end else begin
						stateNxt = ST_IDLE; // RULE_11
					end
				end
			end
			ST_AUG: begin
				if (goCtrl && lastBit) begin
					stateNxt = ST_IDLE;
				end
			end
			default: begin
				stateNxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= stateNxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			polyTerms_r <= `CRC_POLY_RESET;
		end else if (polyWrEn) begin
			polyTerms_r <= {polyWrData[`CRC_ACC_W-1:1], 1'b0}; // RULE_03
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wordHigh_r <= `CRC_BYTE_RESET;
		end else if (wordHighWrEn) begin
			wordHigh_r <= wordByte;
		end
	end

	// Staging shifter and its bit counter
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			staging_r <= `CRC_ACC_RESET;
			bitCnt_r <= '0;
		end else if (fifoPop) begin
			// MSb-first words are left-aligned so the top bit is bit 15
			staging_r <= crcCfg.bitOrderSelect ? maskedWord
				: maskedWord << (`CRC_TOP_LEN - crcCfg.wordLength); // RULE_06 RULE_07
			bitCnt_r <= `CRC_CNT_W'(crcCfg.wordLength); // RULE_16
		end else if (stepEn) begin
			if (lastBit && state_r == ST_DATA) begin
				staging_r <= `CRC_ACC_RESET;
				bitCnt_r <= `CRC_CNT_W'(crcCfg.polyLength); // RULE_10
			end else begin
				staging_r <= crcCfg.bitOrderSelect ? (staging_r >> 1)
					: (staging_r << 1); // RULE_06
				bitCnt_r <= bitCnt_r - 1'b1;
			end
		end
	end

	// Reversed result in LSb-first mode falls out of the same step
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_r <= `CRC_ACC_RESET;
		end else if (seedWrEn) begin
			acc_r <= seedWrData; // RULE_08
		end else if (stepEn) begin
			acc_r <= accNext; // RULE_20 RULE_12
		end
	end

	assign busyNxt = (stateNxt != ST_IDLE) | fifoOutValid | fifoInValid;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busyNxt; // RULE_19
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_r <= 1'b0;
		end else if (busy_r && !busyNxt) begin
			flag_r <= 1'b1; // RULE_13
		end else if (completionFlagClr) begin
			flag_r <= 1'b0; // RULE_14
		end
	end

	// Full lags the FIFO by a cycle; writes into a full FIFO are dropped
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			full_r <= 1'b0;
			scanReady_r <= 1'b0;
		end else begin
			full_r <= ~fifoInReady; // RULE_18
			scanReady_r <= (fifoLevel <=
				(`CRC_FIFO_PTR_W+1)'(`CRC_FIFO_DEPTH - 2));
		end
	end

	assign checkAccumulator = acc_r;
	assign polynomialTerms = polyTerms_r;
	assign inputFull = full_r;
	assign busy = busy_r;
	assign completionFlag = flag_r;
	assign scanReady = scanReady_r;

	// Checks
	logic [`CRC_CNT_W:0] runCnt_r;

	always_ff @(posedge core_clk) begin
		if (sys_rst || state_r != stateNxt) begin
			runCnt_r <= '0;
		end else if (stepEn) begin
			runCnt_r <= runCnt_r + 1'b1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_poly_bit0;
		polynomialTerms[0] == 1'b0;
	endproperty
	a_poly_bit0: assert property (p_poly_bit0) // RULE_03
		else $error("polynomial bit 0 reads one");

	property p_poly_write;
		polyWrEn |=> polynomialTerms[15:1] == $past(polyWrData[15:1]);
	endproperty
	a_poly_write: assert property (p_poly_write) // RULE_04
		else $error("polynomial terms not stored");

	property p_seed;
		seedWrEn |=> checkAccumulator == $past(seedWrData);
	endproperty
	a_seed: assert property (p_seed) // RULE_08
		else $error("seed not loaded");

	property p_acc_width;
		(stepEn && !seedWrEn) |=>
			(checkAccumulator & ~lenMask($past(crcCfg.polyLength))) == '0;
	endproperty
	a_acc_width: assert property (p_acc_width) // RULE_01
		else $error("accumulator bits above length set");

	property p_flag_set;
		$fell(busy) |-> completionFlag;
	endproperty
	a_flag_set: assert property (p_flag_set) // RULE_13
		else $error("busy fell without completion flag");

	property p_flag_sticky;
		(completionFlag && !completionFlagClr) |=> completionFlag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // RULE_14
		else $error("completion flag dropped by itself");

	property p_low_write_starts;
		(wordLowWrEn && goCtrl && !busy && fifoLevel == '0) |=>
			busy ##[0:2] (state_r == ST_DATA);
	endproperty
	a_low_write_starts: assert property (p_low_write_starts) // RULE_09
		else $error("low byte write did not start shifting");

	property p_data_len;
		(state_r == ST_DATA && stateNxt != ST_DATA) |->
			runCnt_r == (`CRC_CNT_W+1)'(crcCfg.wordLength);
	endproperty
	a_data_len: assert property (p_data_len) // RULE_06
		else $error("wrong number of data shifts");

	property p_aug_len;
		(state_r == ST_AUG && stateNxt != ST_AUG) |->
			runCnt_r == (`CRC_CNT_W+1)'(crcCfg.polyLength);
	endproperty
	a_aug_len: assert property (p_aug_len) // RULE_10
		else $error("wrong number of augment shifts");

	property p_full;
		(fifoLevel == (`CRC_FIFO_PTR_W+1)'(`CRC_FIFO_DEPTH) && !fifoPop)
			|=> inputFull;
	endproperty
	a_full: assert property (p_full) // RULE_18
		else $error("full not shown");

	// Busy is registered from the next state, so it stands with any run
	property p_busy_shift;
		(state_r != ST_IDLE) |-> busy;
	endproperty
	a_busy_shift: assert property (p_busy_shift) // RULE_19
		else $error("busy dropped during shifting");

	property p_no_aug;
		(state_r == ST_DATA && !crcCfg.zeroAugmentSelect) |=>
			state_r != ST_AUG;
	endproperty
	a_no_aug: assert property (p_no_aug) // RULE_11
		else $error("augmented without augment select");

	property p_flag_clear;
		(completionFlagClr && !(busy_r && !busyNxt)) |=> !completionFlag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) // RULE_14
		else $error("completion flag not cleared by software");

	property p_acc_hold;
		(!stepEn && !seedWrEn) |=> $stable(checkAccumulator);
	endproperty
	a_acc_hold: assert property (p_acc_hold) // RULE_19
		else $error("accumulator moved while not shifting");

	property p_go_pause;
		!goCtrl |=> $stable(state_r);
	endproperty
	a_go_pause: assert property (p_go_pause) // RULE_17
		else $error("shifter advanced without go");

	c_aug_run: cover property (state_r == ST_AUG ##1 state_r == ST_IDLE);
	c_lsb_word: cover property (state_r == ST_DATA && crcCfg.bitOrderSelect);
	c_flag: cover property ($rose(completionFlag));
	c_full: cover property (inputFull);
	c_scan_take: cover property (scanTake);
endmodule // crc_engine

// >>> bench/crc_scan_model.sv
/*
 Memory scanner model: offers queued words on scanValid/scanWord.
 Assumes the engine takes a word on an edge with scanReady high and no
 competing low byte write; scanHold makes the scanner slow.
*/
module crc_scan_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic scanReady,
	input wire logic wordLowWrEn,
	input wire logic scanHold,
	output logic scanValid,
	output logic [15:0] scanWord
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] q[$];
	logic taken;

	initial begin
		scanValid = 1'h0;
		scanWord = 16'h0000;
	end

	task automatic load(input logic [15:0] d);
		q.push_back(d);
	endtask

	always @(posedge core_clk) begin
		taken = scanValid && scanReady && !wordLowWrEn;
		if (sys_rst) begin
			scanValid <= 1'h0;
		end else begin
			if (taken) begin
				q.delete(0);
			end
			if (!scanValid || taken) begin
				if (q.size() > 0 && !scanHold) begin
					scanValid <= 1'h1;
					scanWord <= q[0];
				end else begin
					// Idle data toggles so a stale word is never mistaken
					scanValid <= 1'h0;
					scanWord <= ~scanWord;
				end
			end
		end
	end
endmodule // crc_scan_model

// >>> bench/configurable_crc_engine_tb_top.sv
/*
 Self-checking bench for the check-value engine: byte writes, scanner
 words, and expected values from a bit-serial reference.
 Assumes crc_engine and its package compiled first.
*/
module configurable_crc_engine_tb_top import crc_engine_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	crc_cfg_t crcCfg = '0;
	logic goCtrl = 1'h0, polyWrEn = 1'h0, seedWrEn = 1'h0;
	logic wordHighWrEn = 1'h0, wordLowWrEn = 1'h0;
	logic completionFlagClr = 1'h0, scanHold = 1'h0;
	logic [15:0] polyWrData = 16'h0000, seedWrData = 16'h0000;
	logic [7:0] wordByte = 8'h00;
	logic scanValid, inputFull, busy, completionFlag, scanReady;
	logic [15:0] scanWord, checkAccumulator, polynomialTerms;
	int err_total = 0;
	int n_checks = 0;
	logic [15:0] w[$];

	crc_engine DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.crcCfg(crcCfg), .goCtrl(goCtrl), .polyWrEn(polyWrEn),
		.polyWrData(polyWrData), .seedWrEn(seedWrEn),
		.seedWrData(seedWrData), .wordHighWrEn(wordHighWrEn),
		.wordLowWrEn(wordLowWrEn), .wordByte(wordByte),
		.scanValid(scanValid), .scanWord(scanWord),
		.completionFlagClr(completionFlagClr),
		.checkAccumulator(checkAccumulator),
		.polynomialTerms(polynomialTerms), .inputFull(inputFull),
		.busy(busy), .completionFlag(completionFlag),
		.scanReady(scanReady));

	crc_scan_model scan (.core_clk(core_clk), .sys_rst(sys_rst),
		.scanReady(scanReady), .wordLowWrEn(wordLowWrEn),
		.scanHold(scanHold), .scanValid(scanValid), .scanWord(scanWord));

	initial begin
		forever #10 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	function automatic crc_cfg_t mk(input logic [3:0] pl, wl,
		input logic ord, aug);
		return {pl, wl, ord, aug};
	endfunction

	function automatic logic [15:0] step(input logic [15:0] a, p, m,
		input logic b, input logic [3:0] pl);
		return (((a << 1) | b) ^ (a[pl] ? p : 16'h0000)) & m;
	endfunction

	function automatic logic [15:0] refCrc(input logic [15:0] seed, pw,
		input crc_cfg_t c, input logic [15:0] d[$]);
		logic [15:0] a, p, m;
		logic b;
		a = seed;
		m = 16'hFFFF >> (4'hF - c.polyLength);
		p = (pw | 16'h0001) & m;
		foreach (d[i]) begin
			for (int n = 0; n <= c.wordLength; n++) begin
				b = c.bitOrderSelect ? d[i][n] : d[i][c.wordLength - n];
				a = step(a, p, m, b, c.polyLength);
			end
		end
		for (int n = 0; c.zeroAugmentSelect && n <= c.polyLength; n++) begin
			a = step(a, p, m, 1'h0, c.polyLength);
		end
		return a;
	endfunction

	// Flag clear rides along so every run must raise the flag again
	task automatic setup(input crc_cfg_t c, input logic [15:0] p, s);
		@(posedge core_clk);
		crcCfg <= c;
		polyWrEn <= 1'h1;
		polyWrData <= p;
		seedWrEn <= 1'h1;
		seedWrData <= s;
		completionFlagClr <= 1'h1;
		@(posedge core_clk);
		polyWrEn <= 1'h0;
		seedWrEn <= 1'h0;
		completionFlagClr <= 1'h0;
		#1;
	endtask

	task automatic wrWord(input logic [15:0] d);
		@(posedge core_clk);
		wordHighWrEn <= 1'h1;
		wordByte <= d[15:8];
		@(posedge core_clk);
		wordHighWrEn <= 1'h0;
		wordLowWrEn <= 1'h1;
		wordByte <= d[7:0];
		@(posedge core_clk);
		wordLowWrEn <= 1'h0;
		#1;
	endtask

	task automatic waitDone(input logic [15:0] exp);
		int i;
		for (i = 0; i < 8 && busy !== 1'h1; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk({15'h0000, busy}, 16'h0001);
		for (i = 0; i < 4000 && busy !== 1'h0; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk({14'h0000, busy, completionFlag}, 16'h0001);
		chk(checkAccumulator, exp);
	endtask

	task automatic runSoft(input logic [15:0] d[$], input logic [15:0] exp);
		foreach (d[i]) begin
			wrWord(d[i]);
		end
		waitDone(exp);
	endtask

	initial begin
		#400000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'h0;
		goCtrl <= 1'h1;
		@(posedge core_clk);
		#1;
		chk(checkAccumulator, 16'h0000);
		chk(polynomialTerms, 16'h0000);
		chk({14'h0000, busy, completionFlag}, 16'h0000);
		chk({14'h0000, inputFull, scanReady}, 16'h0001);
		$display("test reset done");
		w = '{16'h0055, 16'h0066, 16'h0077, 16'h0088};
		setup(mk(4'hF, 4'h7, 1'h0, 1'h1), 16'h8005, 16'h0000);
		chk(polynomialTerms, 16'h8004);
		runSoft(w, 16'h32D6);
		repeat (5) @(posedge core_clk);
		#1;
		chk({15'h0000, completionFlag}, 16'h0001);
		setup(mk(4'hF, 4'h7, 1'h1, 1'h1), 16'h8004, 16'h0000);
		chk({15'h0000, completionFlag}, 16'h0000);
		runSoft(w, 16'h6BA2);
		$display("test example done");
		w = '{16'h0234};
		setup(mk(4'hF, 4'hB, 1'h0, 1'h1), 16'h8004, 16'h0000);
		wrWord(16'hF234);
		waitDone(refCrc(16'h0000, 16'h8004, crcCfg, w));
		w = '{16'h1234};
		setup(mk(4'hF, 4'hF, 1'h0, 1'h0), 16'h8004, 16'h0000);
		wrWord(16'h1234);
		wrWord(16'h0000);
		waitDone(refCrc(16'h0000, 16'h8004,
			mk(4'hF, 4'hF, 1'h0, 1'h1), w));
		$display("test word length done");
		w = '{16'h00C3, 16'h005A, 16'h00FF};
		setup(mk(4'h7, 4'h7, 1'h0, 1'h1), 16'h0006, 16'h00A5);
		chk(checkAccumulator, 16'h00A5);
		scanHold <= 1'h1;
		foreach (w[i]) begin
			scan.load(w[i]);
		end
		repeat (3) @(posedge core_clk);
		scanHold <= 1'h0;
		waitDone(refCrc(16'h00A5, 16'h0006, crcCfg, w));
		$display("test scanner done");
		setup(mk(4'hF, 4'h7, 1'h0, 1'h1), 16'h8004, 16'h0000);
		@(posedge core_clk);
		goCtrl <= 1'h0;
		w.delete();
		// Exactly eight words: the buffer fills but no write is refused
		for (int k = 1; k <= 8; k++) begin
			wrWord(16'(k));
			w.push_back(16'(k));
		end
		@(posedge core_clk);
		#1;
		chk({14'h0000, inputFull, scanReady}, 16'h0002);
		@(posedge core_clk);
		goCtrl <= 1'h1;
		waitDone(refCrc(16'h0000, 16'h8004, crcCfg, w));
		chk({14'h0000, inputFull, scanReady}, 16'h0001);
		$display("test buffer done");
		wrap_up();
	end
endmodule // configurable_crc_engine_tb_top
